// *** etm_pkg.sv ***
// Constants, field layout and mode codes shared by the enhanced timer block
package etm_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_CMP_A = 8'h08;
  localparam logic [7:0] OFS_CMP_B = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // Control one fields
  localparam int RUN_BIT = 0;
  localparam int PERIOD_LSB = 1;
  localparam int CLRSEL_BIT = 4;
  localparam int MODE_A_LSB = 5;
  localparam int FUNC_A_LSB = 7;
  localparam int OC_A_BIT = 9;
  localparam int POL_A_BIT = 10;
  localparam int ALIGN_LSB = 11;
  localparam int CTRL_ONE_W = 13;
  // Control two fields
  localparam int MODE_B_LSB = 0;
  localparam int FUNC_B_LSB = 2;
  localparam int OC_B_BIT = 4;
  localparam int POL_B_BIT = 5;
  localparam int CTRL_TWO_W = 6;
  // Flag bits
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam int FLAG_P_BIT = 2;
  localparam logic [CTRL_ONE_W-1:0] CTRL_ONE_RST = 13'h0000;
  localparam logic [CTRL_TWO_W-1:0] CTRL_TWO_RST = 6'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam int PERIOD_SHIFT = 7;
  localparam int TICK_DIV_DEF = 4;
  localparam logic [1:0] FUNC_INACTIVE = 2'h0;
  localparam logic [1:0] FUNC_ACTIVE = 2'h1;
  localparam logic [1:0] FUNC_PWM = 2'h2;
  localparam logic [1:0] FUNC_SINGLE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00, MODE_CAPTURE = 2'b01, MODE_PWM = 2'b10, MODE_TIMER = 2'b11
  } mode_type;
  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00, ALIGN_UP = 2'b01, ALIGN_DOWN = 2'b10, ALIGN_BOTH = 2'b11
  } align_type;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_type;
endpackage : etm_pkg

// *** etm_timer.sv ***
// Enhanced timer: PWM, single pulse and timer modes behind an AXI4-Lite slave
// Operation
// - All mode bits high: timer mode, pins free
// - PWM shown only with output function 10
// - Clear select high: A period, B duty
// - Clear select low: period field times 128
// - Duty at or above period gives 100%
// - Edge aligned: leading edges at counter reset
// - Centre aligned: double period, centred pulses
// - Alignment field picks edge or centre match
// - PWM sets flags on A, B, period; no period flag when edge aligned with clear select high
// - Output control and polarity shape pin level
// - PWM runs while pins forced fixed
// - Centre: period flag at count-down zero
// - Run rising edge starts pulse A
// - Match B starts pulse B
// - External clock edge sets run bit in single pulse mode
// - Run clear or match A ends pulses
// - Widths: A value, A minus B
// - Single pulse: A and B flag
// - Single pulse: counter zeroed on run rise
// - Clear select in compare: no period flag
// - Counter and compare values ten bits
// - Output function codes force, PWM, single
`timescale 1ns/10ps
`default_nettype none
module etm_timer
#(
  parameter int CNT_W = 10,
  parameter int TICK_DIV = etm_pkg::TICK_DIV_DEF
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [etm_pkg::AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [etm_pkg::AXI_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_external_timer_clock_pin,
  output logic o_timer_out_pin_a,
  output logic o_timer_out_pin_a_drive,
  output logic o_timer_out_pin_b,
  output logic o_timer_out_pin_b_drive
);
  import etm_pkg::*;

  function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge32

  function automatic logic word_hit(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] ofs);
    return {a[AXI_ADDR_W-1:2], 2'b00} == ofs;
  endfunction : word_hit

  function automatic logic pin_level(input logic [1:0] func, input logic oc, input logic pol,
                                     input logic pwm_act, input logic sp_act);
    logic act;
    act = (func == FUNC_INACTIVE) ? 1'b0 :
          (func == FUNC_ACTIVE) ? 1'b1 :
          (func == FUNC_PWM) ? pwm_act : sp_act;
    return (oc ? act : ~act) ^ pol;
  endfunction : pin_level

  // Register state
  logic [CTRL_ONE_W-1:1] ctrl_one_q;
  logic [CTRL_TWO_W-1:0] ctrl_two_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_b_q;
  logic [2:0] flags_q;
  logic run_q;
  logic run_prev_q;
  logic [CNT_W-1:0] cnt_q;
  dir_type dir_q;
  logic [7:0] pre_q;
  logic pulse_b_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic ext_stable_q;

  // Bus state
  logic aw_held_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write channel
  wire do_wr = aw_held_q && w_held_q && !bvalid_q;
  wire wsel_one = do_wr && word_hit(aw_addr_q, OFS_CTRL_ONE);
  wire wsel_two = do_wr && word_hit(aw_addr_q, OFS_CTRL_TWO);
  wire wsel_a = do_wr && word_hit(aw_addr_q, OFS_CMP_A);
  wire wsel_b = do_wr && word_hit(aw_addr_q, OFS_CMP_B);
  wire wsel_flags = do_wr && word_hit(aw_addr_q, OFS_FLAGS);
  wire wsel_ro = do_wr && word_hit(aw_addr_q, OFS_COUNT);
  wire wr_mapped = wsel_one || wsel_two || wsel_a || wsel_b || wsel_flags || wsel_ro;
  wire [31:0] one_now = {19'h0_0000, ctrl_one_q, run_q};
  wire [31:0] one_new = merge32(one_now, w_data_q, w_strb_q);
  wire [31:0] two_new = merge32({26'h000_0000, ctrl_two_q}, w_data_q, w_strb_q);
  wire [31:0] a_new = merge32({22'h00_0000, cmp_a_q}, w_data_q, w_strb_q);
  wire [31:0] b_new = merge32({22'h00_0000, cmp_b_q}, w_data_q, w_strb_q);
  wire [31:0] flag_clr_w = merge32(32'h0000_0000, w_data_q, w_strb_q);

  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // Field decode
  wire [2:0] period_field = ctrl_one_q[PERIOD_LSB+:3];
  wire counter_clear_select = ctrl_one_q[CLRSEL_BIT];
  wire [1:0] mode_a = ctrl_one_q[MODE_A_LSB+:2];
  wire [1:0] chan_a_out_func = ctrl_one_q[FUNC_A_LSB+:2];
  wire chan_a_output_control = ctrl_one_q[OC_A_BIT];
  wire chan_a_polarity = ctrl_one_q[POL_A_BIT];
  wire [1:0] align_sel = ctrl_one_q[ALIGN_LSB+:2];
  wire [1:0] mode_b = ctrl_two_q[MODE_B_LSB+:2];
  wire [1:0] chan_b_out_func = ctrl_two_q[FUNC_B_LSB+:2];
  wire chan_b_output_control = ctrl_two_q[OC_B_BIT];
  wire chan_b_polarity = ctrl_two_q[POL_B_BIT];

  wire both_pwm = (mode_a == MODE_PWM) && (mode_b == MODE_PWM);
  wire is_timer = (mode_a == MODE_TIMER) && (mode_b == MODE_TIMER);
  wire is_single = both_pwm && (chan_a_out_func == FUNC_SINGLE)
                   && (chan_b_out_func == FUNC_SINGLE);
  wire is_pwm = both_pwm && !is_single;
  wire is_centre = is_pwm && (align_sel != ALIGN_EDGE);

  // Period length in counts; period field zero means full range
  wire [CNT_W:0] field_len = (period_field == 3'h0) ? 11'h400 :
                             11'({period_field, 7'h00});
  wire [CNT_W:0] pwm_len = counter_clear_select ? {1'b0, cmp_a_q} : field_len;
  wire [CNT_W:0] pwm_last = (pwm_len == 11'h000) ? 11'h000 : pwm_len - 11'h001;
  wire [CNT_W:0] cmp_last = counter_clear_select ? {1'b0, cmp_a_q} : field_len - 11'h001;
  wire [CNT_W:0] edge_last = is_pwm ? pwm_last : cmp_last;
  wire edge_wrap = ({1'b0, cnt_q} == edge_last) || (&cnt_q);
  // Centre counter turns at the period length, capped at full scale
  wire [CNT_W-1:0] cen_top = pwm_len[CNT_W] ? {CNT_W{1'b1}} : pwm_len[CNT_W-1:0];

  // Timer clock enable
  wire tick = (pre_q == 8'(TICK_DIV - 1));
  wire step = tick && run_q;

  // External clock pin: accept a level once the last two stages agree
  wire ext_agree = (sync2_q == sync3_q);
  wire ext_rise = ext_agree && sync3_q && !ext_stable_q;

  wire run_rise = run_q && !run_prev_q;
  // Matches skip the restart cycle, whose count is stale
  wire dir_ok = !is_centre || (align_sel == ALIGN_BOTH)
                || ((align_sel == ALIGN_UP) && (dir_q == DIR_UP))
                || ((align_sel == ALIGN_DOWN) && (dir_q == DIR_DOWN));
  wire match_a = step && !run_rise && (cnt_q == cmp_a_q) && dir_ok;
  wire match_b = step && !run_rise && (cnt_q == cmp_b_q) && dir_ok;
  wire period_cen = is_centre && (dir_q == DIR_DOWN) && (cnt_q == 10'h001);
  wire period_edge = !is_centre && !is_single && !counter_clear_select && edge_wrap;
  wire match_p = step && !run_rise && (period_cen || period_edge);

  // Raw PWM activity; duty at or beyond the period holds the output on
  wire pwm_act_a = ({1'b0, cnt_q} < {1'b0, cmp_a_q}) || ({1'b0, cmp_a_q} >= pwm_len);
  wire pwm_act_b = ({1'b0, cnt_q} < {1'b0, cmp_b_q}) || ({1'b0, cmp_b_q} >= pwm_len);
  wire sp_act_a = run_q && !run_rise && !match_a;
  wire sp_act_b = run_q && (pulse_b_q || match_b) && !match_a;

  // Pin A carries nothing when A sets the period
  wire drive_a = is_single || (is_pwm && !counter_clear_select);
  wire drive_b = is_single || is_pwm;
  wire lvl_a = pin_level(chan_a_out_func, chan_a_output_control, chan_a_polarity,
                         pwm_act_a, sp_act_a);
  wire lvl_b = pin_level(chan_b_out_func, chan_b_output_control, chan_b_polarity,
                         pwm_act_b, sp_act_b);

  // Run bit: software, external edge and match A all steer it
  logic run_d;
  always_comb begin
    run_d = run_q;
    if (wsel_one) begin
      run_d = one_new[RUN_BIT];
    end
    if (is_single && match_a) begin
      run_d = 1'b0;
    end
    if (is_single && ext_rise) begin
      run_d = 1'b1;
    end
  end

  // Counter next value
  logic [CNT_W-1:0] cnt_d;
  dir_type dir_d;
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (run_rise) begin
      cnt_d = '0;
      dir_d = DIR_UP;
    end else if (step) begin
      if (is_single) begin
        cnt_d = cnt_q + 10'h001;
      end else if (is_centre) begin
        if (dir_q == DIR_UP) begin
          if (cnt_q >= cen_top) begin
            dir_d = DIR_DOWN;
            cnt_d = cnt_q - 10'h001;
          end else begin
            cnt_d = cnt_q + 10'h001;
          end
        end else if (cnt_q == 10'h000) begin
          dir_d = DIR_UP;
          cnt_d = 10'h001;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end else if (edge_wrap) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end
  end

  // Event flags: a set in the clearing cycle survives
  wire [2:0] flag_set = {match_p, match_b, match_a};
  wire [2:0] flag_clr = wsel_flags ? flag_clr_w[2:0] : 3'h0;
  wire [2:0] flags_d = (flags_q & ~flag_clr) | flag_set;

  // Read data
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (word_hit(i_araddr, OFS_CTRL_ONE)) begin
      rd_mux = one_now;
    end else if (word_hit(i_araddr, OFS_CTRL_TWO)) begin
      rd_mux = {26'h000_0000, ctrl_two_q};
    end else if (word_hit(i_araddr, OFS_CMP_A)) begin
      rd_mux = {22'h00_0000, cmp_a_q};
    end else if (word_hit(i_araddr, OFS_CMP_B)) begin
      rd_mux = {22'h00_0000, cmp_b_q};
    end else if (word_hit(i_araddr, OFS_COUNT)) begin
      rd_mux = {22'h00_0000, cnt_q};
    end else if (word_hit(i_araddr, OFS_FLAGS)) begin
      rd_mux = {29'h0000_0000, flags_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_one_q <= CTRL_ONE_RST[CTRL_ONE_W-1:1];
      ctrl_two_q <= CTRL_TWO_RST;
      cmp_a_q <= '0;
      cmp_b_q <= '0;
      flags_q <= FLAGS_RST;
      run_q <= CTRL_ONE_RST[RUN_BIT];
      run_prev_q <= 1'b0;
    end else begin
      if (wsel_one) begin
        ctrl_one_q <= one_new[CTRL_ONE_W-1:1];
      end
      if (wsel_two) begin
        ctrl_two_q <= two_new[CTRL_TWO_W-1:0];
      end
      if (wsel_a) begin
        cmp_a_q <= a_new[CNT_W-1:0];
      end
      if (wsel_b) begin
        cmp_b_q <= b_new[CNT_W-1:0];
      end
      flags_q <= flags_d;
      run_q <= run_d;
      run_prev_q <= run_q;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= '0;
      dir_q <= DIR_UP;
      pre_q <= 8'h00;
      pulse_b_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
      if (!run_q || run_rise) begin
        pulse_b_q <= 1'b0;
      end else if (is_single && match_b) begin
        pulse_b_q <= 1'b1;
      end
    end
  end

  // Three-stage synchroniser; stage one feeds only stage two
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      ext_stable_q <= 1'b0;
    end else begin
      sync1_q <= i_external_timer_clock_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (ext_agree) begin
        ext_stable_q <= sync3_q;
      end
    end
  end

  // Pins registered so they never glitch on decode changes
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_timer_out_pin_a <= 1'b0;
      o_timer_out_pin_b <= 1'b0;
      o_timer_out_pin_a_drive <= 1'b0;
      o_timer_out_pin_b_drive <= 1'b0;
    end else begin
      o_timer_out_pin_a <= drive_a ? lvl_a : 1'b0;
      o_timer_out_pin_b <= drive_b ? lvl_b : 1'b0;
      o_timer_out_pin_a_drive <= drive_a;
      o_timer_out_pin_b_drive <= drive_b;
    end
  end
endmodule : etm_timer
`default_nettype wire

// *** etm_load.sv ***
// Load model for the two timer pins and the external trigger source
`timescale 1ns/10ps
`default_nettype none
module etm_load (
  input wire logic i_mclk,
  input wire logic i_pin_a,
  input wire logic i_drive_a,
  input wire logic i_pin_b,
  input wire logic i_drive_b,
  input wire logic i_win,
  input wire logic i_fire,
  output logic o_ext_pin,
  output logic [11:0] o_high_a,
  output logic [11:0] o_high_b
);
  logic lvl_a, lvl_b;
  logic win_q = 1'b0;
  logic [2:0] fire_cnt = 3'h0;
  // Pull-downs hold an undriven line low
  assign lvl_a = i_drive_a && i_pin_a;
  assign lvl_b = i_drive_b && i_pin_b;
  // Trigger held several cycles to pass the pin filter
  assign o_ext_pin = fire_cnt != 3'h0;
  always @(posedge i_mclk) begin
    win_q <= i_win;
    if (i_fire) begin
      fire_cnt <= 3'h4;
    end else if (fire_cnt != 3'h0) begin
      fire_cnt <= fire_cnt - 3'h1;
    end
    if (i_win && !win_q) begin
      o_high_a <= 12'(lvl_a);
      o_high_b <= 12'(lvl_b);
    end else if (i_win) begin
      o_high_a <= o_high_a + 12'(lvl_a);
      o_high_b <= o_high_b + 12'(lvl_b);
    end
  end
endmodule : etm_load
`default_nettype wire

// *** etm_timer_sva.sv ***
// Port checker for the enhanced timer
`timescale 1ns/10ps
`default_nettype none
module etm_timer_sva
  import etm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [etm_pkg::AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic [etm_pkg::AXI_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic o_timer_out_pin_a,
  input wire logic o_timer_out_pin_a_drive,
  input wire logic o_timer_out_pin_b,
  input wire logic o_timer_out_pin_b_drive
);
  logic wr, settled, sp, tm, pa, pb, lv_a, lv_b;
  logic [12:0] c1_q;
  logic [5:0] c2_q;
  logic [1:0] age_q;
  assign wr = i_awvalid && o_awready && i_wvalid && o_wready;
  assign settled = age_q == 2'h3;
  assign sp = c1_q[8:5] == {FUNC_SINGLE, MODE_PWM} && c2_q[3:0] == {FUNC_SINGLE, MODE_PWM};
  assign tm = c1_q[6:5] == MODE_TIMER && c2_q[1:0] == MODE_TIMER;
  assign pa = settled && c1_q[6:5] == MODE_PWM && c1_q[8:7] == FUNC_INACTIVE
              && !c1_q[CLRSEL_BIT] && c2_q[1:0] == MODE_PWM;
  assign pb = settled && c2_q[1:0] == MODE_PWM && c2_q[3:2] == FUNC_ACTIVE
              && c1_q[6:5] == MODE_PWM;
  assign lv_a = c1_q[OC_A_BIT] ^ c1_q[POL_A_BIT];
  assign lv_b = c2_q[OC_B_BIT] ^ c2_q[POL_B_BIT];
  // Pins trail a control write; age leaves margin
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      c1_q <= CTRL_ONE_RST;
      c2_q <= CTRL_TWO_RST;
      age_q <= 2'h0;
    end else if (wr && i_awaddr == OFS_CTRL_ONE) begin
      c1_q <= i_wdata[12:0];
      age_q <= 2'h0;
    end else if (wr && i_awaddr == OFS_CTRL_TWO) begin
      c2_q <= i_wdata[5:0];
      age_q <= 2'h0;
    end else if (!settled) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence run_write;
    settled && sp && wr && i_awaddr == OFS_CTRL_ONE && i_wdata[RUN_BIT];
  endsequence
  a_write_answer: assert property (wr |-> ##2 o_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response missing");
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (i_arvalid && o_arready && i_araddr > OFS_FLAGS
    |=> o_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_unmapped_write: assert property (wr && i_awaddr > OFS_FLAGS |-> ##2 o_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_timer_pins_free: assert property (settled && tm |-> !o_timer_out_pin_a_drive &&
    !o_timer_out_pin_b_drive) else $error("pin driven in timer mode");
  a_force_inactive: assert property (pa |-> o_timer_out_pin_a_drive &&
    o_timer_out_pin_a == !lv_a) else $error("pin a not at inactive level");
  a_force_active: assert property (pb |-> o_timer_out_pin_b_drive &&
    o_timer_out_pin_b == lv_b) else $error("pin b not at active level");
  a_pulse_starts: assert property (run_write |-> ##[1:4] o_timer_out_pin_a == lv_a)
    else $error("pulse a did not start");
  a_pulse_drive: assert property (settled && sp |-> o_timer_out_pin_a_drive &&
    o_timer_out_pin_b_drive) else $error("single pulse pins not driven");
endmodule : etm_timer_sva
bind etm_timer etm_timer_sva i_etm_timer_sva (.i_mclk, .i_reset, .i_awaddr, .i_awvalid,
  .o_awready, .i_wdata, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_araddr, .i_arvalid,
  .o_arready, .o_rresp, .o_rvalid, .o_timer_out_pin_a, .o_timer_out_pin_a_drive,
  .o_timer_out_pin_b, .o_timer_out_pin_b_drive);
`default_nettype wire

// *** tb_etm_timer.sv ***
// Self-checking bench for the enhanced timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module tb_etm_timer;
  import etm_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, ext, win, fire;
  logic awready, wready, bvalid, arready, rvalid, pa, pad, pb, pbd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] hi_a, hi_b;
  int error_cnt, num_checks;
  etm_timer #(.CNT_W(10), .TICK_DIV(1)) i_etm_timer (.i_mclk(clk), .i_reset(rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_external_timer_clock_pin(ext), .o_timer_out_pin_a(pa),
    .o_timer_out_pin_a_drive(pad), .o_timer_out_pin_b(pb), .o_timer_out_pin_b_drive(pbd));
  etm_load i_etm_load (.i_mclk(clk), .i_pin_a(pa), .i_drive_a(pad), .i_pin_b(pb),
    .i_drive_b(pbd), .i_win(win), .i_fire(fire), .o_ext_pin(ext), .o_high_a(hi_a),
    .o_high_b(hi_b));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 64) begin
      error_cnt++;
      print_verdict();
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 64) begin
      error_cnt++;
      print_verdict();
    end
  endtask : axr
  function automatic logic [31:0] c1(input logic [2:0] per, input logic clr,
      input logic [1:0] md, fn, input logic pol, input logic [1:0] al);
    return {19'h0, al, pol, 1'b1, fn, md, clr, per, 1'b0};
  endfunction : c1
  function automatic logic [31:0] c2(input logic [1:0] md, fn);
    return {26'h0, 2'h1, fn, md};
  endfunction : c2
  function automatic int exp_hi(input logic ctr, inv, input int duty, len, k);
    int h, p;
    p = ctr ? 2 * len : len;
    h = (duty >= len) ? p : (ctr ? 2 * duty - 1 : duty);
    return k * (inv ? p - h : h);
  endfunction : exp_hi
  task automatic setup(input logic [31:0] c1v, c2v, input int a, b, input logic go);
    logic [1:0] r;
    axw(OFS_CTRL_ONE, c1v, r);
    axw(OFS_CTRL_TWO, c2v, r);
    axw(OFS_CMP_A, 32'(a), r);
    axw(OFS_CMP_B, 32'(b), r);
    axw(OFS_FLAGS, 32'h0000_0007, r);
    if (go) axw(OFS_CTRL_ONE, c1v | 32'h0000_0001, r);
  endtask : setup
  task automatic meas_tail(input int n);
    repeat (n) @(posedge clk);
    win <= 1'b0;
    @(posedge clk);
  endtask : meas_tail
  task automatic meas(input int n);
    repeat (4) @(posedge clk);
    win <= 1'b1;
    meas_tail(n);
  endtask : meas
  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    int len, da, db, k;
    {awvalid, wvalid, bready, arvalid, rready, win, fire} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    error_cnt = 0;
    num_checks = 0;
    rst = 1'b1;
    v = $urandom(32'ha31e_8fdc);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      axr(8'(i * 4), d, r);
      `CHK("reset read", 32'h0000_0000, d)
      `CHK("read resp", (i < 6) ? RESP_OKAY : RESP_SLVERR, r)
    end
    axw(8'h18, 32'h0000_0001, r);
    `CHK("unmapped write", RESP_SLVERR, r)
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      axw(OFS_CMP_A + 8'(4 * i[0]), v, r);
      axr(OFS_CMP_A + 8'(4 * i[0]), d, r);
      `CHK("compare value", {22'h0, v[9:0]}, d)
    end
    setup(c1(3'h0, 1'b1, MODE_TIMER, FUNC_INACTIVE, 1'b0, 2'h0),
      c2(MODE_TIMER, FUNC_INACTIVE), 20, 10, 1'b1);
    repeat (70) @(posedge clk);
    axr(OFS_FLAGS, d, r);
    `CHK("timer flags", 32'h0000_0003, d)
    `CHK("drive a", 1'b0, pad)
    `CHK("drive b", 1'b0, pbd)
    for (int i = 0; i < 3; i++) begin
      k = (i == 2) ? 0 : 2 * i + 1;
      len = (k == 0) ? 1024 : k * 128;
      da = $urandom_range(len - 1, 1);
      db = (i == 1) ? len : $urandom_range(len - 1, 1);
      setup(c1(3'(k), 1'b0, MODE_PWM, (i == 2) ? FUNC_INACTIVE : FUNC_PWM, i[0], 2'h0),
        c2(MODE_PWM, (i == 2) ? FUNC_ACTIVE : FUNC_PWM), da, db, 1'b1);
      meas(2 * len);
      `CHK("pwm a high", (i == 2) ? 0 : exp_hi(1'b0, i[0], da, len, 2), hi_a)
      `CHK("pwm b high", (i == 2) ? 2 * len : exp_hi(1'b0, 1'b0, db, len, 2), hi_b)
      axr(OFS_FLAGS, d, r);
      `CHK("pwm flags", {29'h0, 1'b1, i != 1, 1'b1}, d)
    end
    for (int al = 0; al < 4; al++) begin
      len = $urandom_range(200, 40);
      db = $urandom_range(len - 1, 1);
      setup(c1(3'h0, 1'b1, MODE_PWM, FUNC_INACTIVE, 1'b0, 2'(al)),
        c2(MODE_PWM, FUNC_PWM), len, db, 1'b1);
      meas(4 * len);
      `CHK("clr b high", exp_hi(al != 0, 1'b0, db, len, (al != 0) ? 2 : 4), hi_b)
      `CHK("pin a idle", 12'h000, hi_a)
      axr(OFS_FLAGS, d, r);
      if (al != 0) `CHK("period flag", 1'b1, d[FLAG_P_BIT])
    end
    da = $urandom_range(90, 40);
    db = $urandom_range(da - 1, 1);
    v = c1(3'h0, 1'b0, MODE_PWM, FUNC_SINGLE, 1'b0, 2'h0);
    setup(v, c2(MODE_PWM, FUNC_SINGLE), da, db, 1'b0);
    for (int t = 0; t < 3; t++) begin
      axw(OFS_FLAGS, 32'h0000_0007, r);
      @(posedge clk);
      win <= 1'b1;
      if (t == 1) begin
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
      end else begin
        axw(OFS_CTRL_ONE, v | 32'h0000_0001, r);
      end
      if (t == 2) axw(OFS_CTRL_ONE, v, r);
      meas_tail(da + 20);
      if (t < 2) begin
        `CHK("pulse a width", 12'(da), hi_a)
        `CHK("pulse b width", 12'(da - db), hi_b)
        axr(OFS_FLAGS, d, r);
        `CHK("pulse flags", 32'h0000_0003, d)
        axr(OFS_CTRL_ONE, d, r);
        `CHK("run cleared", 1'b0, d[RUN_BIT])
      end else begin
        `CHK("aborted pulse", 1'b1, hi_a < 12'(da))
      end
    end
    print_verdict();
  end
endmodule : tb_etm_timer
`default_nettype wire
